// ### src/bst_tap.sv
// Boundary-scan test access port: state machine, instruction and data registers.
module bst_tap #(
	parameter logic [bst_pkg::ID_W-1:0] ID_CODE = 32'h0000_1001
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic grp1_output_enable_n,
	input wire logic grp2_output_enable_n,
	input wire logic grp1_flow_select,
	input wire logic grp2_flow_select,
	input wire logic [bst_pkg::PIN_W-1:0] pin_in,
	output logic [bst_pkg::PIN_W-1:0] pin_out,
	output logic [bst_pkg::PIN_W-1:0] pin_oe,
	output logic test_mode,
	output logic tdo_path_ready
);
	import bst_pkg::*;

	// ----------------------------------------------------------------
	// Input synchronisers and test clock edges
	// ----------------------------------------------------------------
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic tck_d_q;
	logic rise;
	logic fall;
	logic [PIN_W-1:0] pin_s;
	logic [CTL_W-1:0] ctl_s;

	bst_sync #(.W(3)) u_sync_tap (
		.sys_clk(sys_clk),
		.reset(reset),
		.d({tck, tms, tdi}),
		.q({tck_s, tms_s, tdi_s})
	);

	bst_sync #(.W(PIN_W + CTL_W)) u_sync_pins (
		.sys_clk(sys_clk),
		.reset(reset),
		.d({grp2_flow_select, grp1_flow_select, grp2_output_enable_n, grp1_output_enable_n, pin_in}),
		.q({ctl_s, pin_s})
	);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tck_d_q <= 1'b0;
		end else begin
			tck_d_q <= tck_s;
		end
	end

	assign rise = tck_s & ~tck_d_q;
	assign fall = ~tck_s & tck_d_q;

	// ----------------------------------------------------------------
	// Controller state machine
	// ----------------------------------------------------------------
	bst_state_t st_q;
	bst_state_t st_d;

	always_comb begin
		case (st_q)
			ST_TLR: st_d = tms_s ? ST_TLR : ST_RTI;
			ST_RTI: st_d = tms_s ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: st_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: st_d = tms_s ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: st_d = tms_s ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: st_d = tms_s ? ST_UPD_DR : ST_PA_DR;
			ST_PA_DR: st_d = tms_s ? ST_EX2_DR : ST_PA_DR;
			ST_EX2_DR: st_d = tms_s ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: st_d = tms_s ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: st_d = tms_s ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: st_d = tms_s ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: st_d = tms_s ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: st_d = tms_s ? ST_UPD_IR : ST_PA_IR;
			ST_PA_IR: st_d = tms_s ? ST_EX2_IR : ST_PA_IR;
			ST_EX2_IR: st_d = tms_s ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: st_d = tms_s ? ST_SEL_DR : ST_RTI;
			default: st_d = ST_TLR;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_q <= ST_TLR;
		end else if (rise) begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Instruction decode
	// ----------------------------------------------------------------
	logic [IR_W-1:0] ir_sh_q;
	logic [IR_W-1:0] ir_q;
	bst_dr_t dr_sel;
	logic test_md;
	logic hiz;
	logic bnd_upd;
	logic cap_int;
	logic run_op;
	logic tgl_op;

	always_comb begin
		dr_sel = DR_BYP;
		test_md = 1'b0;
		hiz = 1'b0;
		bnd_upd = 1'b0;
		cap_int = 1'b0;
		run_op = 1'b0;
		tgl_op = 1'b0;
		if (~^ir_q) begin
			case (ir_q)
				OP_EXTEST: begin
					dr_sel = DR_BND;
					test_md = 1'b1;
					bnd_upd = 1'b1;
				end
				OP_ID_READ: dr_sel = DR_ID;
				OP_SAMPLE: begin
					dr_sel = DR_BND;
					bnd_upd = 1'b1;
				end
				OP_HIGHZ: begin
					test_md = 1'b1;
					hiz = 1'b1;
				end
				OP_CLAMP: test_md = 1'b1;
				OP_RUN_TEST: begin
					test_md = 1'b1;
					run_op = 1'b1;
				end
				OP_READ_NORM: begin
					dr_sel = DR_BND;
					cap_int = 1'b1;
				end
				OP_READ_TEST: begin
					dr_sel = DR_BND;
					test_md = 1'b1;
					cap_int = 1'b1;
				end
				OP_CELL_TEST: begin
					dr_sel = DR_BND;
					cap_int = 1'b1;
					bnd_upd = 1'b1;
				end
				OP_TOGGLE: begin
					test_md = 1'b1;
					tgl_op = 1'b1;
				end
				OP_BCR_SCAN: dr_sel = DR_BCR;
				default: dr_sel = DR_BYP;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Instruction register: shift stage and shadow latches
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ir_sh_q <= IR_RESET;
		end else if (rise) begin
			if (st_q == ST_CAP_IR) begin
				ir_sh_q <= IR_CAPTURE;
			end else if (st_q == ST_SH_IR) begin
				ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || st_q == ST_TLR) begin
			ir_q <= IR_RESET;
		end else if (fall && st_q == ST_UPD_IR) begin
			ir_q <= ir_sh_q;
		end
	end

	// ----------------------------------------------------------------
	// Data register shift stages
	// ----------------------------------------------------------------
	logic [BND_W-1:0] bnd_sh_q;
	logic [BND_W-1:0] bnd_q;
	logic [BND_W-1:0] bnd_cap;
	logic [ID_W-1:0] id_sh_q;
	logic [BCR_W-1:0] bcr_sh_q;
	logic [BCR_W-1:0] bcr_q;
	logic byp_q;
	logic a1_en;
	logic a2_en;
	logic b1_en;
	logic b2_en;

	// A port drives when direction is low, B port when it is high.
	assign a1_en = ~ctl_s[0] & ~ctl_s[2];
	assign a2_en = ~ctl_s[1] & ~ctl_s[3];
	assign b1_en = ~ctl_s[0] & ctl_s[2];
	assign b2_en = ~ctl_s[1] & ctl_s[3];
	assign bnd_cap = cap_int ? bnd_q : {b2_en, b1_en, a2_en, a1_en, ctl_s, pin_s};

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			bnd_sh_q <= '0;
			id_sh_q <= '0;
			bcr_sh_q <= BCR_RESET;
			byp_q <= 1'b0;
		end else if (rise && st_q == ST_CAP_DR) begin
			byp_q <= 1'b0;
			id_sh_q <= ID_CODE;
			if (dr_sel == DR_BND) begin
				bnd_sh_q <= bnd_cap;
			end
		end else if (rise && st_q == ST_SH_DR) begin
			case (dr_sel)
				DR_BND: bnd_sh_q <= {tdi_s, bnd_sh_q[BND_W-1:1]};
				DR_ID: id_sh_q <= {tdi_s, id_sh_q[ID_W-1:1]};
				DR_BCR: bcr_sh_q <= {tdi_s, bcr_sh_q[BCR_W-1:1]};
				default: byp_q <= tdi_s;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Shadow latches and run-test operations
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset || st_q == ST_TLR) begin
			bcr_q <= BCR_RESET;
		end else if (fall && st_q == ST_UPD_DR && dr_sel == DR_BCR) begin
			bcr_q <= bcr_sh_q;
		end
	end

	// Only the enable cells get a reset; the rest start as don't-care.
	always_ff @(posedge sys_clk) begin
		if (reset || st_q == ST_TLR) begin
			bnd_q[BND_W-1:CELL_EN_LO] <= '0;
		end else if (fall && st_q == ST_UPD_DR && dr_sel == DR_BND && bnd_upd) begin
			bnd_q <= bnd_sh_q;
		end else if (rise && st_q == ST_RTI && st_d == ST_RTI) begin
			if (tgl_op) begin
				bnd_q[PIN_W-1:0] <= ~bnd_q[PIN_W-1:0];
			end else if (run_op) begin
				case (bcr_q)
					BCR_LFSR: bnd_q[PIN_W-1:0] <= {bnd_q[PIN_W-2:0], bnd_q[PIN_W-1] ^ bnd_q[LFSR_TAP]};
					BCR_PSA: bnd_q[PIN_W-1:0] <= {bnd_q[PIN_W-2:0], bnd_q[PIN_W-1] ^ bnd_q[LFSR_TAP]} ^ pin_s;
					BCR_COUNT: bnd_q[PIN_W-1:0] <= bnd_q[PIN_W-1:0] + 36'h1;
					default: bnd_q[PIN_W-1:0] <= bnd_q[PIN_W-1:0];
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Test data out path
	// ----------------------------------------------------------------
	// The bit is queued one cycle after the rising edge, once the shift has
	// landed, and leaves the buffer on the next falling edge.
	bst_stream_if #(.W(TDO_W)) sx ();
	logic push_q;
	logic in_shift;
	logic lsb;
	logic tdo_q;
	logic tdo_oe_q;
	logic ready_q;

	bst_fifo #(.W(TDO_W), .DEPTH(TDO_DEPTH)) u_tdo_buf (
		.sys_clk(sys_clk),
		.reset(reset),
		.s(sx)
	);

	always_comb begin
		in_shift = (st_q == ST_SH_IR) || (st_q == ST_SH_DR);
		if (st_q == ST_SH_IR) begin
			lsb = ir_sh_q[0];
		end else begin
			case (dr_sel)
				DR_BND: lsb = bnd_sh_q[0];
				DR_ID: lsb = id_sh_q[0];
				DR_BCR: lsb = bcr_sh_q[0];
				default: lsb = byp_q;
			endcase
		end
	end

	assign sx.in_valid = push_q;
	assign sx.in_data = {in_shift, lsb};
	assign sx.out_ready = fall;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			push_q <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			push_q <= rise;
			ready_q <= sx.in_ready;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else if (fall && sx.out_valid) begin
			{tdo_oe_q, tdo_q} <= sx.out_data;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive in test mode
	// ----------------------------------------------------------------
	logic test_q;
	logic [PIN_W-1:0] pout_q;
	logic [PIN_W-1:0] poe_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			test_q <= 1'b0;
			pout_q <= '0;
		end else begin
			test_q <= test_md;
			pout_q <= bnd_q[PIN_W-1:0];
		end
	end

	for (genvar g = 0; g < GRP_N; g++) begin : g_grp
		always_ff @(posedge sys_clk) begin
			if (reset) begin
				poe_q[g*GRP_W +: GRP_W] <= '0;
			end else begin
				poe_q[g*GRP_W +: GRP_W] <= {GRP_W{test_md & ~hiz & bnd_q[GRP_EN_CELL[g]]}};
			end
		end
	end

	assign tdo = tdo_q;
	assign tdo_oe = tdo_oe_q;
	assign pin_out = pout_q;
	assign pin_oe = poe_q;
	assign test_mode = test_q;
	assign tdo_path_ready = ready_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	logic [2:0] tms_cnt_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tms_cnt_q <= '0;
		end else if (rise) begin
			tms_cnt_q <= !tms_s ? 3'h0 : (tms_cnt_q == TLR_TMS_EDGES) ? tms_cnt_q : tms_cnt_q + 3'h1;
		end
	end

	AST_TLR_FIVE: assert property (tms_cnt_q == TLR_TMS_EDGES |-> st_q == ST_TLR)
		else $error("Five high mode-select edges did not reach reset state.");
	AST_CAP_IR: assert property (rise && st_q == ST_CAP_IR |=> ir_sh_q == IR_CAPTURE)
		else $error("Capture-IR did not load the status pattern.");
	AST_SHIFT_IR: assert property (rise && st_q == ST_SH_IR |=> ir_sh_q == {$past(tdi_s), $past(ir_sh_q[7:1])})
		else $error("Instruction shift stage did not shift.");
	AST_UPD_IR: assert property (fall && st_q == ST_UPD_IR |=> ir_q == $past(ir_sh_q))
		else $error("Instruction latch not loaded in Update-IR.");
	AST_PAUSE: assert property (st_q == ST_PA_DR && rise |=> $stable(bnd_sh_q) && $stable(id_sh_q))
		else $error("Pause-DR disturbed the shift stage.");
	AST_BYP_CAP: assert property (rise && st_q == ST_CAP_DR |=> !byp_q)
		else $error("Bypass stage did not capture zero.");
	AST_BCR_CAP: assert property (rise && st_q == ST_CAP_DR |=> $stable(bcr_sh_q))
		else $error("Boundary-control stage changed in Capture-DR.");
	AST_TLR_VALS: assert property (st_q == ST_TLR |=> ir_q == IR_RESET && bcr_q == BCR_RESET && bnd_q[43:40] == 4'h0)
		else $error("Reset state did not restore register values.");
	AST_TDO_ON: assert property (fall && st_q == ST_SH_IR && sx.out_valid |=> tdo_oe)
		else $error("Data out not enabled in Shift-IR.");
	AST_TDO_OFF: assert property (fall && st_q == ST_EX1_IR && sx.out_valid |=> !tdo_oe)
		else $error("Data out not released in Exit1-IR.");
	AST_PARITY: assert property (^ir_q |-> dr_sel == DR_BYP && !test_md)
		else $error("Odd-parity opcode not treated as bypass.");
	AST_TDO_FALL: assert property (!fall |=> $stable(tdo) && $stable(tdo_oe))
		else $error("Data out changed without a falling edge.");

	COV_IR_UPDATE: cover property (fall && st_q == ST_UPD_IR);
	COV_BND_SHIFT: cover property (rise && st_q == ST_SH_DR && dr_sel == DR_BND);
	COV_PAUSE_DR: cover property (rise && st_q == ST_PA_DR && st_d == ST_PA_DR);
	COV_RUN_TEST: cover property (rise && st_q == ST_RTI && run_op);
endmodule : bst_tap

// ### include/bst_pkg.sv
// Shared constants and types of the boundary-scan test access port.
package bst_pkg;
	typedef enum logic [3:0] {
		ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
		ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7,
		ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
		ST_EX1_IR = 4'hc, ST_PA_IR = 4'hd, ST_EX2_IR = 4'he, ST_UPD_IR = 4'hf
	} bst_state_t;
	typedef enum logic [1:0] {
		DR_BND = 2'h0, DR_ID = 2'h1, DR_BYP = 2'h2, DR_BCR = 2'h3
	} bst_dr_t;
	localparam int IR_W = 8;
	localparam int BND_W = 44;
	localparam int BCR_W = 3;
	localparam int ID_W = 32;
	localparam int PIN_W = 36;
	localparam int CTL_W = 4;
	localparam int GRP_W = 9;
	localparam int GRP_N = 4;
	localparam int TDO_W = 2;
	localparam int TDO_DEPTH = 2;
	localparam logic [IR_W-1:0] IR_RESET = 8'h81;
	localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;
	localparam logic [BCR_W-1:0] BCR_RESET = 3'h2;
	localparam logic [BCR_W-1:0] BCR_LFSR = 3'h1;
	localparam logic [BCR_W-1:0] BCR_PSA = 3'h2;
	localparam logic [BCR_W-1:0] BCR_COUNT = 3'h3;
	localparam logic [IR_W-1:0] OP_EXTEST = 8'h00;
	localparam logic [IR_W-1:0] OP_ID_READ = 8'h81;
	localparam logic [IR_W-1:0] OP_SAMPLE = 8'h82;
	localparam logic [IR_W-1:0] OP_HIGHZ = 8'h06;
	localparam logic [IR_W-1:0] OP_CLAMP = 8'h87;
	localparam logic [IR_W-1:0] OP_RUN_TEST = 8'h09;
	localparam logic [IR_W-1:0] OP_READ_NORM = 8'h0a;
	localparam logic [IR_W-1:0] OP_READ_TEST = 8'h8b;
	localparam logic [IR_W-1:0] OP_CELL_TEST = 8'h0c;
	localparam logic [IR_W-1:0] OP_TOGGLE = 8'h8d;
	localparam logic [IR_W-1:0] OP_BCR_SCAN = 8'h8e;
	// Cells 43..40 hold the four port drive enables; 39..36 the control pins.
	localparam int CELL_EN_LO = 40;
	localparam int CELL_CTL_LO = 36;
	// Drive-enable cell for pin groups at bits 0, 9, 18, 27 (1B, 2B, 1A, 2A).
	localparam int GRP_EN_CELL [GRP_N] = '{42, 43, 40, 41};
	localparam int LFSR_TAP = 10;
	localparam logic [2:0] TLR_TMS_EDGES = 3'h5;
endpackage : bst_pkg

// ### include/bst_stream_if.sv
// Valid/ready stream between the scan core and its output buffer.
interface bst_stream_if #(parameter int W = 2);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	modport core (output in_valid, output in_data, input in_ready,
		input out_valid, input out_data, output out_ready);
	modport store (input in_valid, input in_data, output in_ready,
		output out_valid, output out_data, input out_ready);
endinterface : bst_stream_if

// ### src/bst_sync.sv
// Two-flop synchroniser for inputs from outside the system clock domain.
module bst_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;
endmodule : bst_sync

// ### src/bst_fifo.sv
// Small valid/ready buffer; depth and width shape the storage.
module bst_fifo #(
	parameter int W = 2,
	parameter int DEPTH = 2
) (
	input wire logic sys_clk,
	input wire logic reset,
	bst_stream_if.store s
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign s.in_ready = (cnt_q != FULL);
	assign s.out_valid = (cnt_q != '0);
	assign s.out_data = mem[rp_q];
	assign push = s.in_valid & s.in_ready;
	assign pop = s.out_valid & s.out_ready;

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wp_q] <= s.in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == LAST) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == LAST) ? '0 : rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule : bst_fifo

// ### tb/bst_ctrl_model.sv
// Test controller model: drives the link clock, mode select and test data in.
module bst_ctrl_model (
	input wire logic sys_clk,
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 8;

	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// ----------------------------------------
	// Link clock period
	// ----------------------------------------
	// The clock rests low between calls, so it stands still outside frames.
	// The data line returns to its pulled-up level after each bit.
	task automatic bit_cycle(input logic m, input logic d, output logic o, output logic oe);
		@(posedge sys_clk);
		tms <= m;
		tdi <= d;
		// One edge was spent waiting above, so the low phase also lasts HALF cycles.
		repeat (HALF - 1) @(posedge sys_clk);
		o = tdo;
		oe = tdo_oe;
		tck <= 1'b1;
		repeat (HALF) @(posedge sys_clk);
		tck <= 1'b0;
		tdi <= 1'b1;
	endtask : bit_cycle
endmodule : bst_ctrl_model

// ### tb/bst_tap_bench.sv
// Self-checking bench of the boundary-scan test access port.
module bst_tap_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import bst_pkg::*;
	// Arbitrary identification value.
	localparam logic [ID_W-1:0] ID_VAL = 32'h1234_5671;
	localparam logic [PIN_W-1:0] PINS = 36'h9a5c31e7b;
	localparam logic [PIN_W-1:0] LOAD = 36'h5f0c3a96d;
	localparam logic [PIN_W-1:0] LOAD_INV = ~LOAD;
	logic sys_clk;
	logic reset;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe;
	logic oe1_n;
	logic oe2_n;
	logic fs1;
	logic fs2;
	logic [PIN_W-1:0] pin_in;
	logic [PIN_W-1:0] pin_out;
	logic [PIN_W-1:0] pin_oe;
	logic test_mode;
	logic path_ready;
	logic [63:0] d;
	logic [IR_W-1:0] byp [4] = '{8'h03, 8'h84, 8'h01, 8'h88};
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	bst_tap #(.ID_CODE(ID_VAL)) dut_u (
		.sys_clk(sys_clk),
		.reset(reset),
		.tck(tck),
		.tms(tms),
		.tdi(tdi),
		.tdo(tdo),
		.tdo_oe(tdo_oe),
		.grp1_output_enable_n(oe1_n),
		.grp2_output_enable_n(oe2_n),
		.grp1_flow_select(fs1),
		.grp2_flow_select(fs2),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.test_mode(test_mode),
		.tdo_path_ready(path_ready)
	);

	bst_ctrl_model ctl_u (
		.sys_clk(sys_clk),
		.tck(tck),
		.tms(tms),
		.tdi(tdi),
		.tdo(tdo),
		.tdo_oe(tdo_oe)
	);

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic step(input logic m);
		logic o;
		logic oe;
		ctl_u.bit_cycle(m, 1'b1, o, oe);
	endtask : step

	// Scan from Run-Test/Idle back to it; a nonzero pau parks the scan in the
	// pause state after that many bits, to prove the partial contents survive.
	task automatic scan(input logic ir, input int n, input int pau, input logic [63:0] din,
		output logic [63:0] dout);
		logic o;
		logic oe;
		dout = '0;
		step(1'b1);
		if (ir) begin
			step(1'b1);
		end
		step(1'b0);
		step(1'b0);
		for (int i = 0; i < n; i++) begin
			ctl_u.bit_cycle(i == n - 1 || i == pau - 1, din[i], o, oe);
			dout[i] = o;
			if (i == 0) begin
				cmp("tdo_oe in shift", 64'h1, oe);
			end
			if (i == pau - 1) begin
				repeat (3) step(1'b0);
				step(1'b1);
				step(1'b0);
			end
		end
		ctl_u.bit_cycle(1'b1, 1'b1, o, oe);
		cmp("tdo_oe after exit", 64'h0, oe);
		step(1'b0);
	endtask : scan

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 15000) begin
			n_mismatch++;
			complete_run();
		end
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		reset = 1'b1;
		oe1_n = 1'b0;
		fs1 = 1'b1;
		oe2_n = 1'b0;
		fs2 = 1'b0;
		pin_in = PINS;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (4) @(posedge sys_clk);
		cmp("test_mode after reset", 64'h0, test_mode);
		cmp("pin_oe after reset", 64'h0, pin_oe);
		cmp("tdo path ready", 64'h1, path_ready);
		step(1'b0);
		scan(1'b1, 8, 3, OP_EXTEST, d);
		cmp("ir capture", IR_CAPTURE, d);
		cmp("test_mode extest", 64'h1, test_mode);
		cmp("pin_oe benign", 64'h0, pin_oe);
		scan(1'b0, 44, 20, {8'ha0, LOAD}, d);
		cmp("boundary capture", {8'h64, PINS}, d);
		cmp("pin_out applied", LOAD, pin_out);
		cmp("pin_oe applied", {9'h1ff, 9'h000, 9'h1ff, 9'h000}, pin_oe);
		repeat (5) step(1'b1);
		cmp("test_mode after tms high", 64'h0, test_mode);
		step(1'b0);
		scan(1'b0, 32, 0, 64'h0, d);
		cmp("id read", ID_VAL, d);
		foreach (byp[k]) begin
			scan(1'b1, 8, 0, byp[k], d);
			cmp("ir capture", IR_CAPTURE, d);
			scan(1'b0, 3, 0, 64'h5, d);
			cmp("bypass path", 64'h2, d);
		end
		repeat (5) step(1'b1);
		step(1'b0);
		scan(1'b1, 8, 0, OP_BCR_SCAN, d);
		scan(1'b0, 3, 0, 64'h3, d);
		cmp("control register reset", BCR_RESET, d);
		// All four enable cells set, so every pin group drives whenever test mode allows it.
		scan(1'b1, 8, 0, OP_EXTEST, d);
		scan(1'b0, 44, 0, {8'hf0, LOAD}, d);
		cmp("pin_oe all groups", 64'hfffffffff, pin_oe);
		scan(1'b1, 8, 0, OP_READ_NORM, d);
		scan(1'b0, 44, 0, 64'h0, d);
		cmp("boundary latch read", {8'hf0, LOAD}, d);
		cmp("test_mode read", 64'h0, test_mode);
		cmp("pin_oe read", 64'h0, pin_oe);
		scan(1'b1, 8, 0, OP_HIGHZ, d);
		cmp("test_mode highz", 64'h1, test_mode);
		cmp("pin_oe highz", 64'h0, pin_oe);
		scan(1'b1, 8, 0, OP_CLAMP, d);
		cmp("pin_oe clamp", 64'hfffffffff, pin_oe);
		cmp("pin_out clamp", LOAD, pin_out);
		scan(1'b1, 8, 0, OP_TOGGLE, d);
		step(1'b0);
		cmp("pin_out toggled", LOAD_INV, pin_out);
		step(1'b0);
		cmp("pin_out toggled back", LOAD, pin_out);
		// The control register still holds 011 from the scan above, so the latches count up.
		scan(1'b1, 8, 0, OP_RUN_TEST, d);
		repeat (3) step(1'b0);
		cmp("pin_out count", LOAD + 36'h3, pin_out);
		complete_run();
	end
endmodule : bst_tap_bench
